// ### hw/adcsp_serial_port.sv
`timescale 1ns/1ps
module adcsp_serial_port #(
  parameter int RES_W = adcsp_pkg::RES_W,
  parameter int DEPTH = adcsp_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic port_type_select,
  input wire logic [3:0] dual_pin_in,
  output logic [3:0] dual_pin_out,
  output logic [3:0] dual_pin_oe,
  input wire logic [adcsp_pkg::DIV_W-1:0] serial_clock_divider_in,
  output logic [adcsp_pkg::DIV_W-1:0] serial_clock_divider_out,
  output logic [adcsp_pkg::DIV_W-1:0] serial_clock_divider_oe,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic conv_busy,
  input wire logic res_valid,
  input wire logic [RES_W-1:0] res_data,
  output logic res_ready,
  output logic serial_result_out,
  output logic frame_marker
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  adcsp_pkg::adcsp_state_e st_q;
  adcsp_pkg::adcsp_state_e st_d;
  logic [RES_W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [RES_W-1:0] sh_q;
  logic [adcsp_pkg::HC_W-1:0] hc_q;
  logic [adcsp_pkg::HC_W-1:0] half_len;
  logic [adcsp_pkg::BC_W-1:0] bc_q;
  logic sclk_int_q;
  logic s_prev_q;
  logic rd_prev_q;
  logic [adcsp_pkg::DIV_W-1:0] div_eff;
  logic serial_sel;
  logic clk_ext;
  logic frame_pol;
  logic clk_inv;
  logic read_mode;
  logic read_en;
  logic fifo_valid;
  logic push;
  logic pop;
  logic load_master;
  logic load_slave;
  logic par_pop;
  logic m_tick;
  logic m_fall;
  logic m_last;
  logic s_clk;
  logic s_rise;

  // Clock source and read mode pins count only with the serial port on; frame polarity and clock inversion pins act in parallel mode too.
  assign serial_sel = port_type_select;
  assign clk_ext = dual_pin_in[adcsp_pkg::DP_CLK_SRC];
  assign frame_pol = dual_pin_in[adcsp_pkg::DP_FRAME_POL];
  assign clk_inv = dual_pin_in[adcsp_pkg::DP_CLK_INV];
  assign read_mode = dual_pin_in[adcsp_pkg::DP_READ_MODE];
  assign read_en = !cs_n && !rd_n;
  assign fifo_valid = cnt_q != '0;
  assign push = res_valid && res_ready;

  // The divider pins count only in master read-after-convert mode.
  assign div_eff = (serial_sel && !clk_ext && !read_mode) ?
                   serial_clock_divider_in : adcsp_pkg::DIV_NONE;
  assign half_len =
    adcsp_pkg::HC_W'(adcsp_pkg::HALF_BASE) << div_eff;

  // Read during convert starts on a busy conversion; read after convert waits.
  assign load_master = st_q == adcsp_pkg::ADCSP_IDLE && serial_sel &&
                       !clk_ext && read_en && fifo_valid &&
                       (read_mode ? conv_busy : !conv_busy);
  assign load_slave = st_q == adcsp_pkg::ADCSP_IDLE && serial_sel &&
                      clk_ext && read_en && fifo_valid;
  // A read strobe on an empty buffer must not move the pointers.
  assign par_pop = !serial_sel && !cs_n && rd_n && !rd_prev_q && fifo_valid;
  assign pop = load_master || load_slave || par_pop;

  assign m_tick = st_q == adcsp_pkg::ADCSP_MASTER &&
                  hc_q == half_len - 1'b1;
  assign m_fall = m_tick && sclk_int_q;
  assign m_last = m_fall && bc_q == adcsp_pkg::BC_W'(RES_W - 1);

  // The host clock is gated by chip select and optionally inverted.
  assign s_clk = (sclk_in ^ clk_inv) && !cs_n;
  assign s_rise = st_q == adcsp_pkg::ADCSP_SLAVE &&
                  s_clk && !s_prev_q;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      adcsp_pkg::ADCSP_IDLE: begin
        if (load_master) begin
          st_d = adcsp_pkg::ADCSP_MASTER;
        end else if (load_slave) begin
          st_d = adcsp_pkg::ADCSP_SLAVE;
        end
      end
      adcsp_pkg::ADCSP_MASTER: begin
        if (m_last) begin
          st_d = adcsp_pkg::ADCSP_IDLE;
        end
      end
      adcsp_pkg::ADCSP_SLAVE: begin
        if (cs_n) begin
          st_d = adcsp_pkg::ADCSP_IDLE;
        end
      end
      default: begin
        st_d = adcsp_pkg::ADCSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= adcsp_pkg::ADCSP_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Two-entry result buffer; a busy serial port holds words back here.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wp_q] <= res_data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      res_ready <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_d;
      res_ready <= cnt_d != CW'(DEPTH);
    end
  end

  // Internal clock generator and bit counter for master transfers.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hc_q <= '0;
      bc_q <= '0;
      sclk_int_q <= 1'b0;
    end else if (st_q != adcsp_pkg::ADCSP_MASTER) begin
      hc_q <= '0;
      bc_q <= '0;
      sclk_int_q <= 1'b0;
    end else if (m_tick) begin
      hc_q <= '0;
      sclk_int_q <= !sclk_int_q;
      if (m_fall) begin
        bc_q <= bc_q + 1'b1;
      end
    end else begin
      hc_q <= hc_q + 1'b1;
    end
  end

  // Result shifter; in slave mode the chain input fills from the bottom.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sh_q <= '0;
    end else if (load_master || load_slave) begin
      sh_q <= mem_q[rp_q];
    end else if (m_fall) begin
      sh_q <= {sh_q[RES_W-2:0], 1'b0};
    end else if (s_rise) begin
      sh_q <= {sh_q[RES_W-2:0], read_mode};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_prev_q <= 1'b0;
      rd_prev_q <= 1'b1;
    end else begin
      s_prev_q <= s_clk;
      rd_prev_q <= rd_n;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      serial_result_out <= 1'b0;
      frame_marker <= 1'b0;
      sclk_out <= 1'b0;
      sclk_oe <= 1'b0;
    end else begin
      serial_result_out <= st_d == adcsp_pkg::ADCSP_IDLE ? 1'b0 :
                           (load_master || load_slave) ?
                           mem_q[rp_q][RES_W-1] :
                           (m_fall || s_rise) ? sh_q[RES_W-2] :
                           sh_q[RES_W-1];
      frame_marker <=
        (st_d == adcsp_pkg::ADCSP_MASTER) ^ frame_pol;
      sclk_oe <= serial_sel && !clk_ext;
      sclk_out <= (m_tick ? !sclk_int_q : sclk_int_q) ^ clk_inv;
    end
  end

  // Parallel mode drives result bits 2-3 and 4-7 while a read is enabled and a result is buffered.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dual_pin_out <= '0;
      dual_pin_oe <= '0;
      serial_clock_divider_out <= '0;
      serial_clock_divider_oe <= '0;
    end else begin
      dual_pin_out <=
        mem_q[rp_q][adcsp_pkg::PAR_HI:adcsp_pkg::PAR_LO];
      dual_pin_oe <= {4{!serial_sel && read_en && fifo_valid}};
      serial_clock_divider_out <=
        mem_q[rp_q][adcsp_pkg::PAR_DIV_HI:adcsp_pkg::PAR_DIV_LO];
      serial_clock_divider_oe <=
        {adcsp_pkg::DIV_W{!serial_sel && read_en && fifo_valid}};
    end
  end
endmodule

// ### hw/adcsp_pkg.sv
package adcsp_pkg;
  localparam int RES_W = 16;
  localparam int DIV_W = 2;
  localparam int FIFO_DEPTH = 2;
  // Shortest half period of the internal serial clock, in core cycles.
  localparam int HALF_BASE = 1;
  localparam int HC_W = 8;
  localparam int BC_W = 5;
  // Dual-role pin positions within the bits 4 to 7 group.
  localparam int DP_CLK_SRC = 0;
  localparam int DP_FRAME_POL = 1;
  localparam int DP_CLK_INV = 2;
  localparam int DP_READ_MODE = 3;
  localparam int PAR_LO = 4;
  localparam int PAR_HI = 7;
  localparam int PAR_DIV_LO = 2;
  localparam int PAR_DIV_HI = 3;
  localparam logic [DIV_W-1:0] DIV_NONE = 2'h0;

  typedef enum logic [1:0] {
    ADCSP_IDLE = 2'b00,
    ADCSP_MASTER = 2'b01,
    ADCSP_SLAVE = 2'b10
  } adcsp_state_e;
endpackage

// ### test/adcsp_serial_port_chk.sv
`timescale 1ns/1ps
module adcsp_serial_port_chk (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic port_type_select,
  input wire logic [3:0] dual_pin_in,
  input wire logic [3:0] dual_pin_oe,
  input wire logic [1:0] serial_clock_divider_in,
  input wire logic [1:0] serial_clock_divider_oe,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic conv_busy,
  input wire logic frame_marker
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  logic act;
  logic ser;
  logic ck;
  assign act = frame_marker != dual_pin_in[1];
  assign ser = port_type_select;
  assign ck = sclk_out ^ dual_pin_in[2];
  chk_serial_hiz: assert property (
    ser && $past(ser) |-> !serial_clock_divider_oe && !dual_pin_oe)
    else $error("pins driven in serial mode");
  chk_par_gate: assert property (
    dual_pin_oe != 4'h0 |-> dual_pin_oe == 4'hF
    && serial_clock_divider_oe == 2'h3
    && !$past(ser) && !$past(cs_n) && !$past(rd_n))
    else $error("parallel drive without read");
  chk_master_clk: assert property (
    sclk_oe |-> $past(ser) && !$past(dual_pin_in[0]))
    else $error("clock driven outside master mode");
  chk_slave_mark: assert property (
    ser && dual_pin_in[0] && $stable(dual_pin_in)
    |=> frame_marker == $past(dual_pin_in[1]))
    else $error("frame marker active in slave mode");
  chk_idle_clk: assert property (
    sclk_oe && !act && $stable(dual_pin_in) |-> !ck)
    else $error("idle clock level wrong");
  chk_div_slow: assert property (
    sclk_oe && act && !dual_pin_in[3] && serial_clock_divider_in == 2'h1
    && $rose(ck) |=> $stable(sclk_out) ##1 $changed(sclk_out))
    else $error("divided clock half period wrong");
  chk_fast_clk: assert property (
    sclk_oe && act && dual_pin_in[3] && $rose(ck) |=> $fell(ck))
    else $error("undivided clock half period wrong");
  chk_read_mode: assert property (
    sclk_oe && $rose(act) && $stable(dual_pin_in)
    |-> $past(conv_busy) == dual_pin_in[3])
    else $error("transfer started in wrong phase");
  cover property ($rose(act));
  cover property (dual_pin_oe == 4'hF);
  cover property (ser && dual_pin_in[0] && !cs_n && $rose(ck));
endmodule

bind adcsp_serial_port adcsp_serial_port_chk u_chk (.*);

// ### test/adcsp_host_model.sv
`timescale 1ns/1ps
module adcsp_host_model (
  input wire logic core_clk,
  input wire logic sclk_out,
  input wire logic serial_result_out,
  input wire logic inv,
  output logic sclk_in
);
  logic [15:0] word;
  initial sclk_in = 1'b0;
  task automatic get_master();
    word = 16'h0;
    repeat (16) begin
      @(posedge (sclk_out ^ inv));
      word = {word[14:0], serial_result_out};
    end
  endtask
  // The clock stands at its inactive level outside a frame.
  task automatic get_slave();
    sclk_in <= inv;
    repeat (4) @(posedge core_clk);
    word = 16'h0;
    repeat (16) begin
      sclk_in <= ~inv;
      repeat (4) @(posedge core_clk);
      word = {word[14:0], serial_result_out};
      sclk_in <= inv;
      repeat (4) @(posedge core_clk);
    end
  endtask
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk, resetn, port_type_select, cs_n, rd_n, conv_busy;
  logic res_valid, res_ready, sclk_in, sclk_out, sclk_oe;
  logic serial_result_out, frame_marker;
  logic [3:0] dual_pin_in, dual_pin_out, dual_pin_oe;
  logic [1:0] serial_clock_divider_in, serial_clock_divider_out;
  logic [1:0] serial_clock_divider_oe;
  logic [15:0] res_data;
  logic [3:0] cfg [4] = '{4'h0, 4'hE, 4'h9, 4'h5};
  logic [15:0] wd [4] = '{16'h9AB5, 16'h6E01, 16'hC35A, 16'h8421};
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  adcsp_serial_port dut (
    .core_clk(core_clk), .resetn(resetn),
    .port_type_select(port_type_select),
    .dual_pin_in(dual_pin_in), .dual_pin_out(dual_pin_out),
    .dual_pin_oe(dual_pin_oe),
    .serial_clock_divider_in(serial_clock_divider_in),
    .serial_clock_divider_out(serial_clock_divider_out),
    .serial_clock_divider_oe(serial_clock_divider_oe),
    .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .cs_n(cs_n), .rd_n(rd_n), .conv_busy(conv_busy),
    .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready),
    .serial_result_out(serial_result_out), .frame_marker(frame_marker)
  );
  adcsp_host_model host (.core_clk, .sclk_out, .serial_result_out,
    .inv(dual_pin_in[2]), .sclk_in);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic push(input logic [15:0] w, input logic last);
    res_valid <= 1'b1;
    res_data <= w;
    do @(posedge core_clk); while (res_ready !== 1'b1);
    if (last) res_valid <= 1'b0;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    resetn = 1'b0;
    port_type_select = 1'b0;
    dual_pin_in = 4'h0;
    serial_clock_divider_in = 2'h1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    conv_busy = 1'b0;
    res_valid = 1'b0;
    res_data = 16'h0;
    tick(8);
    resetn <= 1'b1;
    tick(2);
    check("ready", res_ready, 1'b1);
    push(16'hA5C3, 1'b0);
    push(16'h1238, 1'b1);
    tick(2);
    check("full", res_ready, 1'b0);
    cs_n <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd_n <= 1'b0;
      tick(3);
      check("par_oe", dual_pin_oe, i < 2 ? 4'hF : 4'h0);
      check("pdoe", serial_clock_divider_oe, i < 2 ? 2'h3 : 2'h0);
      if (i < 2) begin
        check("par_hi", dual_pin_out, i ? 4'h3 : 4'hC);
        check("par_lo", serial_clock_divider_out, i ? 2'h2 : 2'h0);
      end
      rd_n <= 1'b1;
      tick(2);
    end
    cs_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      port_type_select <= 1'b1;
      dual_pin_in <= cfg[i];
      conv_busy <= i < 2 && !cfg[i][3];
      tick(3);
      push(wd[i], 1'b1);
      tick(1);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      if (i < 2) begin
        tick(6);
        check("m_wait", frame_marker, cfg[i][1]);
        conv_busy <= cfg[i][3];
        host.get_master();
        check("m_act", frame_marker, !cfg[i][1]);
        check("m_word", host.word, wd[i]);
        tick(80);
        check("m_mark", frame_marker, cfg[i][1]);
        check("m_clk", sclk_oe, 1'b1);
      end else begin
        tick(4);
        check("s_msb", serial_result_out, wd[i][15]);
        host.get_slave();
        check("s_word", host.word, {wd[i][14:0], cfg[i][3]});
        check("s_clk", sclk_oe, 1'b0);
      end
      check("doe", serial_clock_divider_oe, 2'h0);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      tick(4);
      check("idle", serial_result_out, 1'b0);
    end
    print_verdict();
  end
endmodule
